// File: ast_far_end.sv
`default_nettype none
module ast_far_end
(
  input  wire logic sys_clk,
  output var logic  extScanIn,
  output var logic  extConvIn,
  output var logic  extPauseIn,
  output var logic  extTbIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tbRun;
  initial {extScanIn, extConvIn, extPauseIn, extTbIn, tbRun} = 5'h00;
  // A 10 MHz timebase, 50 ns in each phase.
  always #50 extTbIn = tbRun ? !extTbIn : extTbIn;
  // One 100 ns pulse, then quiet long enough for a whole conversion or the start of a scan.
  task automatic strobe(input logic isScan);
    @(negedge sys_clk);
    {extScanIn, extConvIn} = isScan ? 2'h2 : 2'h1;
    repeat (4) @(negedge sys_clk);
    {extScanIn, extConvIn} = 2'h0;
    repeat (30) @(negedge sys_clk);
  endtask : strobe
endmodule : ast_far_end
`default_nettype wire

// File: ast_pkg.sv
`default_nettype none
package ast_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned PULSE_MIN_NS = 50;
  localparam int unsigned PULSE_MAX_NS = 100;
  localparam int unsigned HOLD_DELAY_MIN_NS = 50;
  localparam int unsigned HOLD_WIDTH_MIN_NS = 400;
  localparam int unsigned HOLD_WIDTH_MAX_NS = 500;
  localparam int unsigned FAST_TB_HZ = 20000000;
  localparam int unsigned SLOW_TB_HZ = 100000;
  localparam int unsigned EXT_TB_MAX_HZ = 20000000;
  localparam int unsigned EXT_TB_PHASE_NS = 23;
  // Least times round up to whole cycles.
  localparam int unsigned PULSE_CYC = (PULSE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned HOLD_DLY_CYC = (HOLD_DELAY_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned HOLD_WID_CYC = (HOLD_WIDTH_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned FAST_DIV = CLK_HZ / FAST_TB_HZ;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_TB_HZ;
  localparam int CNT_W = 24;
  localparam int DIV_W = 9;
  localparam int TMR_W = 5;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [DIV_W-1:0] DIV_ONE = 9'h001;
  localparam logic [TMR_W-1:0] TMR_ZERO = 5'h00;
  localparam logic [TMR_W-1:0] TMR_ONE = 5'h01;
  localparam logic [TMR_W-1:0] PULSE_LEN = TMR_W'(PULSE_CYC);
  localparam logic [TMR_W-1:0] HOLD_DLY = TMR_W'(HOLD_DLY_CYC);
  localparam logic [TMR_W-1:0] HOLD_WID = TMR_W'(HOLD_WID_CYC);
  localparam logic [DIV_W-1:0] FAST_DIV_V = DIV_W'(FAST_DIV);
  localparam logic [DIV_W-1:0] SLOW_DIV_V = DIV_W'(SLOW_DIV);
  typedef enum logic {AST_SRC_INT, AST_SRC_EXT} ast_src_t;
endpackage : ast_pkg
`default_nettype wire

// File: ast_pulse_gen.sv
`default_nettype none
module ast_pulse_gen
  import ast_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             trig,
  input  wire logic [TMR_W-1:0] delay,
  input  wire logic [TMR_W-1:0] width,
  output logic                  active
);
  logic [TMR_W-1:0] dly_q, dly_d, wid_q, wid_d;
  logic active_q, active_d;

  always_comb
  begin
    dly_d = dly_q;
    wid_d = wid_q;
    active_d = active_q;
    if (trig)
    begin
      dly_d = delay;
      wid_d = width;
      active_d = 1'b0;
    end
    else if (dly_q != TMR_ZERO)
    begin
      dly_d = dly_q - TMR_ONE;
      active_d = (dly_q == TMR_ONE);
    end
    else if (wid_q != TMR_ZERO)
    begin
      wid_d = wid_q - TMR_ONE;
      active_d = (wid_q != TMR_ONE);
    end
    else
      active_d = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dly_q <= TMR_ZERO;
      wid_q <= TMR_ZERO;
      active_q <= 1'b0;
    end
    else if (clkEn)
    begin
      dly_q <= dly_d;
      wid_q <= wid_d;
      active_q <= active_d;
    end
  end

  assign active = active_q;
endmodule : ast_pulse_gen
`default_nettype wire

// File: ast_scan_timing.sv
`default_nettype none
module ast_scan_timing
  import ast_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clkEn,
  input  wire logic                   acqStartTrig,
  input  wire logic                   swStop,
  input  wire logic                   swGate,
  input  wire logic [ast_pkg::CNT_W-1:0] sampleCount,
  input  wire logic [ast_pkg::CNT_W-1:0] scanInterval,
  input  wire logic [ast_pkg::CNT_W-1:0] sampleInterval,
  input  wire logic [ast_pkg::CNT_W-1:0] convPerScan,
  input  wire ast_pkg::ast_src_t      scanSrc,
  input  wire ast_pkg::ast_src_t      convSrc,
  input  wire ast_pkg::ast_src_t      tbSrc,
  input  wire logic                   tbSlowSel,
  input  wire logic                   scanInvert,
  input  wire logic                   convInvert,
  input  wire logic                   pauseInvert,
  input  wire logic                   tbInvert,
  input  wire logic                   scanBusyMode,
  input  wire logic                   scanOutCfg,
  input  wire logic                   convOutCfg,
  input  wire logic                   holdOutCfg,
  input  wire logic                   holdEnable,
  input  wire logic                   holdInvert,
  input  wire logic                   extScanIn,
  input  wire logic                   extConvIn,
  input  wire logic                   extPauseIn,
  input  wire logic                   extTbIn,
  output logic                        scanStartClockOut,
  output logic                        scanStartClockOe,
  output logic                        convertClockOut,
  output logic                        convertClockOe,
  output logic                        holdDonePulseOut,
  output logic                        holdDonePulseOe,
  output logic                        seqActive,
  output logic                        scanActive
);
  import ast_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic scanEdge, convEdge, pauseLvl, tbLvl, tbEdge, unusedLvl, unusedEdge;
  logic holdRaw, unusedTbLvl;

  ast_sync_det uScanDet (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .rawIn(extScanIn),
    .invert(scanInvert), .level(unusedLvl), .edgePulse(scanEdge));
  ast_sync_det uConvDet (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .rawIn(extConvIn),
    .invert(convInvert), .level(), .edgePulse(convEdge));
  ast_sync_det uPauseDet (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .rawIn(extPauseIn),
    .invert(pauseInvert), .level(pauseLvl), .edgePulse(unusedEdge));
  ast_sync_det uTbDet (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .rawIn(extTbIn),
    .invert(tbInvert), .level(unusedTbLvl), .edgePulse(tbEdge));

  ////////////////////////////////////////////////////////////////////////////
  // Internal timebase ticks come from a divider of the system clock.
  logic [DIV_W-1:0] div_q, div_d;
  logic tick;

  always_comb
  begin
    div_d = div_q - DIV_ONE;
    if (div_q <= DIV_ONE)
      div_d = tbSlowSel ? SLOW_DIV_V : FAST_DIV_V;
  end

  assign tick = (tbSrc == AST_SRC_EXT) ? tbEdge : (div_q <= DIV_ONE);

  ////////////////////////////////////////////////////////////////////////////
  logic seq_q, seq_d, scan_q, scan_d, gated_q, gated_d;
  logic [CNT_W-1:0] si_q, si_d, sc_q, sc_d, s2_q, s2_d, cv_q, cv_d;
  logic [TMR_W-1:0] sp_q, sp_d, cp_q, cp_d;
  logic scanOut_q, scanOut_d, convOut_q, convOut_d;
  logic scanReq, scanGo, convGo, lastConv;

  always_comb
  begin
    seq_d = seq_q;
    si_d = si_q;
    sc_d = sc_q;
    scanReq = 1'b0;
    if (!seq_q && acqStartTrig)
    begin
      seq_d = 1'b1;
      si_d = scanInterval;
      sc_d = sampleCount;
    end
    else if (seq_q)
    begin
      if (tick && scanSrc == AST_SRC_INT)
      begin
        if (si_q <= CNT_ONE)
        begin
          si_d = scanInterval;
          scanReq = 1'b1;
        end
        else
          si_d = si_q - CNT_ONE;
      end
      if (scanSrc == AST_SRC_EXT)
        scanReq = scanEdge;
    end
    // The gate is sampled only when no scan runs, so a running scan completes.
    gated_d = scan_q ? gated_q : (pauseLvl | swGate);
    scanGo = seq_q && scanReq && !scan_q && !gated_d && sc_q != CNT_ZERO;
    if (scanGo)
      sc_d = sc_q - CNT_ONE;
    if (seq_q && (swStop || (sc_q == CNT_ZERO && !scan_q)))
      seq_d = 1'b0;
  end

  always_comb
  begin
    scan_d = scan_q;
    s2_d = s2_q;
    cv_d = cv_q;
    convGo = 1'b0;
    lastConv = (cv_q <= CNT_ONE);
    if (scanGo)
    begin
      scan_d = 1'b1;
      s2_d = sampleInterval;
      cv_d = convPerScan;
    end
    else if (scan_q && seq_q)
    begin
      if (convSrc == AST_SRC_INT)
      begin
        if (s2_q <= CNT_ONE)
        begin
          convGo = 1'b1;
          s2_d = sampleInterval;
        end
        else
          s2_d = s2_q - CNT_ONE;
      end
      else
        convGo = convEdge;
      if (convGo)
      begin
        cv_d = cv_q - CNT_ONE;
        if (lastConv)
        begin
          scan_d = 1'b0;
          s2_d = sampleInterval;
        end
      end
    end
    else
      scan_d = 1'b0;
    sp_d = scanGo ? PULSE_LEN : (sp_q != TMR_ZERO ? sp_q - TMR_ONE : TMR_ZERO);
    cp_d = convGo ? PULSE_LEN : (cp_q != TMR_ZERO ? cp_q - TMR_ONE : TMR_ZERO);
    scanOut_d = scanBusyMode ? scan_d : (sp_d != TMR_ZERO);
    convOut_d = !(cp_d != TMR_ZERO);
  end

  // Hold timing runs from each convert issued to the converter.
  ast_pulse_gen uHold (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .trig(convGo & holdEnable), .delay(HOLD_DLY), .width(HOLD_WID), .active(holdRaw));

  ////////////////////////////////////////////////////////////////////////////
  logic hold_q, hold_d, scanOe_q, convOe_q, holdOe_q;

  assign hold_d = holdRaw ^ holdInvert;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      div_q <= DIV_ONE;
      seq_q <= 1'b0;
      si_q <= CNT_ZERO;
      sc_q <= CNT_ZERO;
      scan_q <= 1'b0;
      gated_q <= 1'b0;
      s2_q <= CNT_ZERO;
      cv_q <= CNT_ZERO;
      sp_q <= TMR_ZERO;
      cp_q <= TMR_ZERO;
      scanOut_q <= 1'b0;
      convOut_q <= 1'b1;
      hold_q <= 1'b0;
      scanOe_q <= 1'b0;
      convOe_q <= 1'b0;
      holdOe_q <= 1'b0;
    end
    else if (clkEn)
    begin
      div_q <= div_d;
      seq_q <= seq_d;
      si_q <= si_d;
      sc_q <= sc_d;
      scan_q <= scan_d;
      gated_q <= gated_d;
      s2_q <= s2_d;
      cv_q <= cv_d;
      sp_q <= sp_d;
      cp_q <= cp_d;
      scanOut_q <= scanOut_d;
      convOut_q <= convOut_d;
      hold_q <= hold_d;
      scanOe_q <= scanOutCfg;
      convOe_q <= convOutCfg;
      holdOe_q <= holdOutCfg;
    end
  end

  assign scanStartClockOut = scanOut_q;
  assign scanStartClockOe = scanOe_q;
  assign convertClockOut = convOut_q;
  assign convertClockOe = convOe_q;
  assign holdDonePulseOut = hold_q;
  assign holdDonePulseOe = holdOe_q;
  assign seqActive = seq_q;
  assign scanActive = scan_q;
endmodule : ast_scan_timing
`default_nettype wire

// File: ast_scan_timing_props.sv
`default_nettype none
module ast_scan_timing_props
  import ast_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic convOutCfg,
  input wire logic scanBusyMode,
  input wire logic holdEnable,
  input wire logic holdInvert,
  input wire logic scanStartClockOut,
  input wire logic scanStartClockOe,
  input wire logic convertClockOut,
  input wire logic convertClockOe,
  input wire logic holdDonePulseOut,
  input wire logic holdDonePulseOe,
  input wire logic seqActive
);
  // Counts the hold pulse length; a hold output that never falls is left to the bench counts.
  logic [4:0] holdRun_q;
  logic [4:0] holdRun_d;
  always_comb holdRun_d = (rst_n && holdDonePulseOut) ? holdRun_q + 5'h01 : 5'h00;
  always_ff @(posedge sys_clk) holdRun_q <= holdRun_d;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_oe_reset_off:
    assert property (!$past(rst_n) |-> !scanStartClockOe && !convertClockOe && !holdDonePulseOe)
    else $error("Output enable set right after reset");
  a_oe_follows_cfg:
    assert property ($past(rst_n) |-> convertClockOe == $past(convOutCfg))
    else $error("Convert enable does not follow its setting");
  a_scan_pulse_width:
    assert property ($rose(scanStartClockOut) && !scanBusyMode |=> scanStartClockOut ##1 !scanStartClockOut)
    else $error("Scan start pulse is not two cycles");
  a_conv_pulse_width:
    assert property ($fell(convertClockOut) |=> !convertClockOut ##1 convertClockOut)
    else $error("Convert pulse is not two cycles low");
  a_conv_in_seq:
    assert property ($fell(convertClockOut) |-> $past(seqActive))
    else $error("Convert pulse outside a sequence");
  a_hold_follows_conv:
    assert property ($fell(convertClockOut) && holdEnable && !holdInvert |-> ##[1:4] $rose(holdDonePulseOut))
    else $error("Hold pulse missing after convert");
  a_hold_width:
    assert property ($fell(holdDonePulseOut) && !holdInvert |-> holdRun_q inside {[16:20]})
    else $error("Hold pulse width out of range");
  a_busy_ends_conv:
    assert property (scanBusyMode && $fell(scanStartClockOut) |-> ##[0:2] !convertClockOut)
    else $error("Busy output fell away from last convert");
  c_busy_end: cover property (scanBusyMode && $fell(scanStartClockOut));
  c_hold: cover property ($rose(holdDonePulseOut));
  c_conv: cover property ($fell(convertClockOut));
endmodule : ast_scan_timing_props
`default_nettype wire

// File: ast_sync_det.sv
`default_nettype none
module ast_sync_det
  import ast_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic rawIn,
  input  wire logic invert,
  output logic      level,
  output logic      edgePulse
);
  logic meta_q, meta_d, stab_q, stab_d, last_q, last_d;

  always_comb
  begin
    meta_d = rawIn;
    stab_d = meta_q;
    last_d = stab_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      stab_q <= 1'b0;
      last_q <= 1'b0;
    end
    else if (clkEn)
    begin
      meta_q <= meta_d;
      stab_q <= stab_d;
      last_q <= last_d;
    end
  end

  // Both samples are inverted alike, so a change of polarity or reset makes no false edge.
  assign level = stab_q ^ invert;
  assign edgePulse = level & ~(last_q ^ invert);
endmodule : ast_sync_det
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench
  import ast_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n, clkEn, acqStartTrig, swStop, swGate, tbSlowSel, scanInvert, convInvert;
  logic pauseInvert, tbInvert, scanBusyMode, scanOutCfg, convOutCfg, holdOutCfg;
  logic holdEnable, holdInvert, extScanIn, extConvIn, extPauseIn, extTbIn;
  logic [CNT_W-1:0] sampleCount, scanInterval, sampleInterval, convPerScan;
  ast_src_t scanSrc, convSrc, tbSrc;
  logic scanStartClockOut, scanStartClockOe, convertClockOut, convertClockOe;
  logic holdDonePulseOut, holdDonePulseOe, seqActive, scanActive, pScan, pConv, pHold;
  int errors = 0, num_checks = 0, scans, convs, holds, early, cyc = 0;
  ast_scan_timing dut (.*);
  ast_far_end far (.*);
  initial forever #12.5 sys_clk = !sys_clk;
  ////////////////////////////////////////
  // Outputs are sampled at the falling edge, where they have settled.
  always @(negedge sys_clk)
  begin
    cyc++;
    if (scanStartClockOut === 1'b1 && pScan === 1'b0) scans++;
    if (convertClockOut === 1'b0 && pConv === 1'b1) convs++;
    if (convertClockOut === 1'b0 && pConv === 1'b1 && scans == 0) early++;
    if (holdDonePulseOut === 1'b1 && pHold === 1'b0) holds++;
    {pScan, pConv, pHold} = {scanStartClockOut, convertClockOut, holdDonePulseOut};
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic checkRun(input logic seq, input logic [4:0] s, input logic [5:0] c, h);
    chk({seqActive, 5'(scans), 6'(convs), 6'(holds), 6'(early)}, {seq, s, c, h, 6'h00});
  endtask : checkRun
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cycles
  task automatic startSeq(input logic [CNT_W-1:0] n);
    {scans, convs, holds, early} = '0;
    sampleCount = n;
    @(negedge sys_clk) acqStartTrig = 1'b1;
    @(negedge sys_clk) acqStartTrig = 1'b0;
  endtask : startSeq
  // The hold pulse trails its convert, so a short tail is waited out as well.
  task automatic waitIdle();
    for (int k = 0; k < 4000 && seqActive !== 1'b0; k++)
      @(negedge sys_clk);
    cycles(30);
  endtask : waitIdle
  ////////////////////////////////////////
  task automatic tReset();
    cycles(3);
    chk({scanStartClockOe, convertClockOe, holdDonePulseOe, convertClockOut}, 24'h1);
    {scanOutCfg, convOutCfg, holdOutCfg} = 3'h7;
    cycles(2);
    chk({scanStartClockOe, convertClockOe, holdDonePulseOe}, 24'h7);
    $display("reset test done");
  endtask : tReset
  task automatic tInternal();
    startSeq(24'h2);
    waitIdle();
    checkRun(1'h0, 5'h02, 6'h06, 6'h06);
    scanBusyMode = 1'b1;
    startSeq(24'h1);
    waitIdle();
    checkRun(1'h0, 5'h01, 6'h03, 6'h03);
    scanBusyMode = 1'b0;
    $display("internal test done");
  endtask : tInternal
  task automatic tTimebase();
    tbSrc = AST_SRC_EXT;
    {tbInvert, far.tbRun, scanInterval} = {2'h3, 24'h5};
    startSeq(24'h2);
    waitIdle();
    checkRun(1'h0, 5'h02, 6'h06, 6'h06);
    tbSrc = AST_SRC_INT;
    {tbSlowSel, far.tbRun, scanInterval} = {2'h2, 24'h2};
    startSeq(24'h1);
    cycles(300);
    checkRun(1'h1, 5'h00, 6'h00, 6'h00);
    waitIdle();
    checkRun(1'h0, 5'h01, 6'h03, 6'h03);
    {tbSlowSel, scanInterval} = {1'b0, 24'h3c};
    $display("timebase test done");
  endtask : tTimebase
  task automatic tGate();
    swGate = 1'b1;
    startSeq(24'h1);
    cycles(300);
    checkRun(1'h1, 5'h00, 6'h00, 6'h00);
    {swGate, pauseInvert} = 2'h1;
    cycles(300);
    checkRun(1'h1, 5'h00, 6'h00, 6'h00);
    far.extPauseIn = 1'b1;
    for (int k = 0; k < 400 && scanActive !== 1'b1; k++)
      @(negedge sys_clk);
    far.extPauseIn = 1'b0;
    waitIdle();
    checkRun(1'h0, 5'h01, 6'h03, 6'h03);
    startSeq(24'h3);
    cycles(20);
    swStop = 1'b1;
    cycles(1);
    swStop = 1'b0;
    cycles(5);
    checkRun(1'h0, 5'h00, 6'h00, 6'h00);
    pauseInvert = 1'b0;
    $display("gate test done");
  endtask : tGate
  task automatic tExternal();
    scanSrc = AST_SRC_EXT;
    convSrc = AST_SRC_EXT;
    scanInvert = 1'b1;
    startSeq(24'h2);
    far.strobe(1'b0);
    for (int k = 0; k < 8; k++)
      far.strobe(k % 4 == 0);
    waitIdle();
    checkRun(1'h0, 5'h02, 6'h06, 6'h06);
    far.strobe(1'b1);
    far.strobe(1'b0);
    checkRun(1'h0, 5'h02, 6'h06, 6'h06);
    scanSrc = AST_SRC_INT;
    convSrc = AST_SRC_INT;
    $display("external test done");
  endtask : tExternal
  ////////////////////////////////////////
  initial
  begin
    {rst_n, clkEn, acqStartTrig, swStop, swGate, tbSlowSel} = 6'h10;
    {scanInvert, convInvert, pauseInvert, tbInvert, scanBusyMode} = 5'h00;
    {scanOutCfg, convOutCfg, holdOutCfg, holdEnable, holdInvert} = 5'h02;
    {sampleCount, scanInterval, sampleInterval, convPerScan} = {24'h0, 24'h3c, 24'h18, 24'h3};
    scanSrc = AST_SRC_INT;
    convSrc = AST_SRC_INT;
    tbSrc = AST_SRC_INT;
    cycles(10);
    rst_n = 1'b1;
    tReset();
    tInternal();
    tTimebase();
    tGate();
    tExternal();
    summarize();
  end
endmodule : testbench
bind ast_scan_timing ast_scan_timing_props props (.*);
`default_nettype wire
